// >>> hw/sal_ara.sv
`timescale 1ns/1ps
`default_nettype none
module sal_ara (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic [6:0] own_addr,
    input wire logic pending,
    output logic sda_oe,
    output logic ara_done
);
    import sal_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_DATA, ST_MACK}
        sal_ara_state_type;

    sal_ara_state_type st_q;
    logic scl_p_q, sda_p_q, oe_q, done_q;
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic rise, fall, start, stop;

    assign rise = scl & ~scl_p_q;
    assign fall = ~scl & scl_p_q;
    assign start = scl & scl_p_q & sda_p_q & ~sda;
    assign stop = scl & scl_p_q & ~sda_p_q & sda;
    assign sda_oe = oe_q;
    assign ara_done = done_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl;
            sda_p_q <= sda;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
            done_q <= 1'b0;
            shift_q <= 8'h00;
            cnt_q <= 4'h0;
        end
        else
        begin
            done_q <= 1'b0;
            if (start)
            begin
                st_q <= ST_ADDR;
                cnt_q <= 4'h0;
                oe_q <= 1'b0;
            end
            else if (stop)
            begin
                st_q <= ST_IDLE;
                oe_q <= 1'b0;
            end
            else
            begin
                unique case (st_q)
                    ST_IDLE: ;
                    ST_ADDR:
                    begin
                        if (rise)
                        begin
                            shift_q <= {shift_q[6:0], sda};
                            cnt_q <= cnt_q + 4'h1;
                        end
                        // RULE_07: acknowledge a read of the response address.
                        if (fall && cnt_q == BITS_PER_BYTE)
                        begin
                            if (shift_q == {ARA_ADDR, 1'b1} && pending)
                            begin
                                st_q <= ST_ACK;
                                oe_q <= 1'b1;
                            end
                            else
                                st_q <= ST_IDLE;
                        end
                    end
                    ST_ACK:
                    begin
                        // RULE_07: start returning the own address.
                        if (fall)
                        begin
                            st_q <= ST_DATA;
                            shift_q <= {own_addr, 1'b0};
                            cnt_q <= 4'h0;
                            oe_q <= ~own_addr[6];
                        end
                    end
                    ST_DATA:
                    begin
                        // RULE_08: a released one seen low means arbitration lost.
                        if (rise && shift_q[7] && !sda)
                        begin
                            st_q <= ST_IDLE;
                            oe_q <= 1'b0;
                        end
                        else if (rise)
                        begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            cnt_q <= cnt_q + 4'h1;
                        end
                        else if (fall && cnt_q == BITS_PER_BYTE)
                        begin
                            st_q <= ST_MACK;
                            oe_q <= 1'b0;
                        end
                        else if (fall)
                            oe_q <= ~shift_q[7];
                    end
                    ST_MACK:
                    begin
                        if (rise)
                        begin
                            done_q <= 1'b1;
                            st_q <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    a_lost_release: assert property ( // RULE_08
        @(posedge aclk) disable iff (!aresetn)
        st_q == ST_DATA && rise && shift_q[7] && !sda && !start && !stop
        |=> !oe_q && st_q == ST_IDLE)
    else $error("Lost arbitration did not release the data line.");

    a_ack_drive: assert property ( // RULE_07
        @(posedge aclk) disable iff (!aresetn)
        st_q == ST_ACK |-> oe_q)
    else $error("Response address acknowledge not driven.");
endmodule : sal_ara
`default_nettype wire

// >>> hw/sal_pkg.sv
// Contract
// RULE_01: Alert asserts on warning, over-limit, critical, or triggered conversion done.
// RULE_02: Alert stays latched until status read or a successful alert response.
// RULE_03: Alert asserts again after clearing while its cause is still present.
// RULE_04: Asserting the alert never stops a running conversion sequence.
// RULE_05: Alert output is open-drain and only ever pulls the line low.
// RULE_06: Clearing the alert output enable releases the alert line high.
// RULE_07: A pending device answers the alert response address with its address.
// RULE_08: Arbitration decides, lower address wins; loser keeps alert low.
// RULE_09: Finished alert response read releases alert when the cause is gone.
// RULE_10: Alert flag clears by status read or by disabling the alert.
// RULE_11: After power-on reset all status flags read zero without alarms.
// RULE_12: Status read clears watchdog flags after a conversion, once fault gone.
// RULE_13: Output latches ignore alert response, clear on status read, re-set.
// RULE_14: Transparent latch mode clears that output latch; latched mode resumes.
// RULE_15: Writing one to a peak register's bit zero resets the peak.
// RULE_16: Shunt range has a base that gain widens two, four or eight times.
// RULE_17: Bus voltage measurement offers two selectable full-scale ranges.
// RULE_18: Shunt and bus channels have separate resolution and averaging settings.
// RULE_19: Software should latch the critical output driving a hot-swap enable.
// RULE_20: Reset masks all status, disables functions, outputs active-low transparent.
// RULE_21: Conversion done flag sets only after the whole conversion cycle finishes.
// RULE_22: Critical pin enable gates only the pin, never the critical flags.
// RULE_23: An event during a clearing status read keeps its flag and alert.
package sal_pkg;
    localparam int AXI_AW = 8;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_PEAK_POS = 8'h0C;
    localparam logic [7:0] ADDR_PEAK_NEG = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [6:0] ARA_ADDR = 7'h0C;
    localparam logic [15:0] PEAK_POS_RST = 16'h8000;
    localparam logic [15:0] PEAK_NEG_RST = 16'h7FFF;
    localparam logic [8:0] SHUNT_BASE_MV = 9'h028;
    localparam logic [5:0] BUS_BASE_V = 6'h10;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef struct packed {
        logic critical_positive_flag_neg;
        logic critical_positive_flag_pos;
        logic over;
        logic warn;
    } sal_fault_type;

    typedef struct packed {
        logic conv_en;
        logic critical_positive_flag_en;
        logic over_en;
        logic warn_en;
        logic critical_pin_enable;
        logic alert_output_enable;
    } sal_mask_type;

    typedef struct packed {
        logic triggered_mode;
        logic [3:0] bus_adc;
        logic [3:0] shunt_adc;
        logic bus_range_32v;
        logic [1:0] shunt_range_gain;
        logic [2:0] active_high;
        logic [2:0] latch_mode;
    } sal_cfg_type;

    localparam int MASK_W = $bits(sal_mask_type);
    localparam int CFG_W = $bits(sal_cfg_type);
    localparam sal_mask_type MASK_RST = '0;
    localparam sal_cfg_type CFG_RST = '0;
endpackage : sal_pkg

// >>> hw/sal_top.sv
`timescale 1ns/1ps
`default_nettype none
module sal_top #(
    // Arbitrary neutral default slave address.
    parameter logic [6:0] OWN_ADDR = 7'h40
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sal_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [sal_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire sal_pkg::sal_fault_type fault_present,
    input wire logic conv_cycle_done,
    input wire logic sample_valid,
    input wire logic [15:0] sample,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic alert_o,
    output logic alert_oe,
    output logic [2:0] watchdog_pin,
    output sal_pkg::sal_cfg_type cfg_o,
    output logic [8:0] shunt_fs_mv,
    output logic [5:0] bus_fs_v
);
    import sal_pkg::*;

    if (OWN_ADDR == ARA_ADDR || OWN_ADDR == 7'h00)
    begin : g_bad_addr
        $error("Own address collides with a reserved address.");
    end

    logic aw_fire, w_fire, ar_fire, do_write, stat_rd, cfg_wr;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_have_q, w_have_q;
    logic [AXI_AW-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q, wm;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    sal_mask_type mask_q;
    sal_cfg_type cfg_q;
    logic [3:0] fp, fen, fault_q, fault_set, fault_clr;
    logic conv_q, conv_seen_q, alert_q, alert_d, alert_clr;
    logic alert_oe_q, cond, ara_done, ara_oe;
    logic [15:0] peak_pos_q, peak_neg_q;
    logic pos_clr, neg_clr;
    logic [2:0] act, pin_en, lat_q, lat_d, pin_act, pin_q, hi;
    logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q, zero_q;
    logic [8:0] shunt_fs_q;
    logic [5:0] bus_fs_q;

    function automatic logic known(input logic [AXI_AW-1:0] a);
        known = a == ADDR_STATUS || a == ADDR_MASK || a == ADDR_CONFIG ||
            a == ADDR_PEAK_POS || a == ADDR_PEAK_NEG;
    endfunction : known

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] s);
        merge = old;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
                merge[8*i +: 8] = nw[8*i +: 8];
        end
    endfunction : merge

    function logic [31:0] reg_word(input logic [AXI_AW-1:0] a);
        case (a)
            ADDR_STATUS: reg_word = {26'h0, alert_q, conv_q, fault_q};
            ADDR_MASK: reg_word = {{(32-MASK_W){1'b0}}, mask_q};
            ADDR_CONFIG: reg_word = {{(32-CFG_W){1'b0}}, cfg_q};
            ADDR_PEAK_POS: reg_word = {16'h0, peak_pos_q};
            ADDR_PEAK_NEG: reg_word = {16'h0, peak_neg_q};
            default: reg_word = 32'h0;
        endcase
    endfunction : reg_word

    assign aw_fire = awvalid & awready_q;
    assign w_fire = wvalid & wready_q;
    assign ar_fire = arvalid & arready_q;
    assign do_write = aw_have_q & w_have_q & ~bvalid_q;
    assign stat_rd = ar_fire && araddr == ADDR_STATUS;
    assign cfg_wr = do_write && awaddr_q == ADDR_CONFIG;
    // Evaluated in a process so that register changes behind the function
    // also refresh the merged write word.
    always_comb
    begin
        wm = merge(reg_word(awaddr_q), wdata_q, wstrb_q);
    end
    // RULE_15: a one in bit zero of a peak register resets it.
    assign pos_clr = do_write && awaddr_q == ADDR_PEAK_POS &&
        wstrb_q[0] && wdata_q[0];
    assign neg_clr = do_write && awaddr_q == ADDR_PEAK_NEG &&
        wstrb_q[0] && wdata_q[0];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (aw_fire)
                awaddr_q <= awaddr;
            if (w_fire)
            begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            aw_have_q <= (aw_have_q & ~do_write) | aw_fire;
            w_have_q <= (w_have_q & ~do_write) | w_fire;
            awready_q <= ~((aw_have_q & ~do_write) | aw_fire);
            wready_q <= ~((w_have_q & ~do_write) | w_fire);
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bready)
                bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= RESP_OKAY;
        end
        else
        begin
            if (ar_fire)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= reg_word(araddr);
                rresp_q <= known(araddr) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rready)
                rvalid_q <= 1'b0;
            arready_q <= ~((rvalid_q & ~rready) | ar_fire);
        end
    end

    // RULE_18: separate resolution and averaging fields per channel.
    always_ff @(posedge aclk)
    begin
        // RULE_20: everything masked, disabled, active low, transparent.
        if (!aresetn)
        begin
            mask_q <= MASK_RST;
            cfg_q <= CFG_RST;
        end
        else
        begin
            if (do_write && awaddr_q == ADDR_MASK)
                mask_q <= sal_mask_type'(wm[MASK_W-1:0]);
            if (cfg_wr)
                cfg_q <= sal_cfg_type'(wm[CFG_W-1:0]);
        end
    end

    assign fp = fault_present;
    assign fen = {mask_q.critical_positive_flag_en, mask_q.critical_positive_flag_en, mask_q.over_en,
        mask_q.warn_en};
    assign hi = cfg_q.active_high;

    always_comb
    begin
        // RULE_22: critical flags follow the function enable only.
        fault_set = fp & fen;
        // RULE_12: clear only after a conversion and with the fault gone.
        fault_clr = (stat_rd && conv_seen_q) ? ~fp : 4'h0;
        // RULE_01: any enabled fault or a triggered conversion end.
        cond = (|fault_set) |
            (conv_cycle_done & cfg_q.triggered_mode & mask_q.conv_en);
        // RULE_10: status read or alert disable drops the flag.
        // RULE_09: a finished response clears only without a cause.
        alert_clr = stat_rd | (ara_done & ~cond) |
            ~mask_q.alert_output_enable;
        // RULE_23: the set term wins over every clear.
        alert_d = (alert_q & ~alert_clr) |
            (cond & mask_q.alert_output_enable);
    end

    // RULE_11: flags start at zero; fault flags rise only on enabled causes, conv_q on any conversion end.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fault_q <= 4'h0;
            conv_q <= 1'b0;
            conv_seen_q <= 1'b0;
        end
        else
        begin
            // RULE_23: an event in a clearing read cycle is kept.
            fault_q <= (fault_q & ~fault_clr) | fault_set;
            // RULE_21: set only by the end of a whole conversion cycle.
            conv_q <= (conv_q & ~stat_rd & ~cfg_wr) | conv_cycle_done;
            // RULE_04: the converter is observed here, never held back.
            conv_seen_q <= (conv_seen_q & ~stat_rd) | conv_cycle_done;
        end
    end

    // RULE_02: the alert stays until an explicit clear.
    // RULE_03: a lasting cause re-sets the alert at once.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alert_q <= 1'b0;
            alert_oe_q <= 1'b0;
        end
        else
        begin
            alert_q <= alert_d;
            // RULE_06: no pull-down while the alert output is disabled.
            alert_oe_q <= alert_d & mask_q.alert_output_enable;
        end
    end

    assign act = {fp[3] | fp[2], fp[1], fp[0]};
    assign pin_en = {mask_q.critical_pin_enable, mask_q.over_en,
        mask_q.warn_en};
    // RULE_13: latches clear on a status read and re-set on the fault.
    // RULE_14: transparent mode holds the latch cleared.
    assign lat_d = cfg_q.latch_mode & (act | (lat_q & ~{3{stat_rd}}));
    assign pin_act = (cfg_q.latch_mode & lat_d) | (~cfg_q.latch_mode & act);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lat_q <= 3'h0;
            pin_q <= 3'h7;
        end
        else
        begin
            lat_q <= lat_d;
            // RULE_22: the critical pin enable gates only this pin.
            pin_q <= ~((pin_en & pin_act) ^ hi);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            peak_pos_q <= PEAK_POS_RST;
            peak_neg_q <= PEAK_NEG_RST;
        end
        else
        begin
            // RULE_15: a sample in the clear cycle becomes the new peak.
            if (pos_clr)
                peak_pos_q <= sample_valid ? sample : PEAK_POS_RST;
            else if (sample_valid && $signed(sample) > $signed(peak_pos_q))
                peak_pos_q <= sample;
            if (neg_clr)
                peak_neg_q <= sample_valid ? sample : PEAK_NEG_RST;
            else if (sample_valid && $signed(sample) < $signed(peak_neg_q))
                peak_neg_q <= sample;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shunt_fs_q <= SHUNT_BASE_MV;
            bus_fs_q <= BUS_BASE_V;
        end
        else
        begin
            // RULE_16: base range doubled per gain step, up to eight.
            shunt_fs_q <= SHUNT_BASE_MV << cfg_q.shunt_range_gain;
            // RULE_17: the lower or the doubled bus range.
            bus_fs_q <= cfg_q.bus_range_32v ? BUS_BASE_V << 1 : BUS_BASE_V;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            zero_q <= 1'b0;
        end
        else
        begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            // RULE_05: open-drain pins only ever drive low.
            zero_q <= 1'b0;
        end
    end

    // RULE_08: a device that loses keeps its alert pending.
    sal_ara u_ara (
        .aclk(aclk),
        .aresetn(aresetn),
        .scl(scl_s2_q),
        .sda(sda_s2_q),
        .own_addr(OWN_ADDR),
        .pending(alert_q),
        .sda_oe(ara_oe),
        .ara_done(ara_done)
    );

    assign awready = awready_q;
    assign wready = wready_q;
    assign bresp = bresp_q;
    assign bvalid = bvalid_q;
    assign arready = arready_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign rvalid = rvalid_q;
    assign sda_o = zero_q;
    assign sda_oe = ara_oe;
    assign alert_o = zero_q;
    assign alert_oe = alert_oe_q;
    assign watchdog_pin = pin_q;
    assign cfg_o = cfg_q;
    assign shunt_fs_mv = shunt_fs_q;
    assign bus_fs_v = bus_fs_q;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_held;
        alert_q && !stat_rd && !ara_done && mask_q.alert_output_enable;
    endsequence

    sequence s_ara_clear;
        ara_done && !cond;
    endsequence

    a_alert_sets: assert property ( // RULE_01
        cond && mask_q.alert_output_enable |=> alert_q && alert_oe_q)
    else $error("Alert did not assert on its cause.");

    a_alert_latched: assert property ( // RULE_02
        s_held |=> alert_q)
    else $error("Alert dropped without a clear.");

    a_alert_rearm: assert property ( // RULE_03
        stat_rd && cond && mask_q.alert_output_enable
        |=> alert_q && alert_oe_q)
    else $error("Alert not re-asserted while cause present.");

    a_open_drain: assert property ( // RULE_05
        !alert_o && !sda_o)
    else $error("Open-drain pin driven high.");

    a_disable_release: assert property ( // RULE_06 RULE_10
        !mask_q.alert_output_enable |=> !alert_oe_q && !alert_q)
    else $error("Disabled alert still pulls the line.");

    a_ara_release: assert property ( // RULE_09
        s_ara_clear |=> !alert_q && !alert_oe_q)
    else $error("Alert response did not release the alert.");

    a_flag_clear: assert property ( // RULE_12
        stat_rd && conv_seen_q && !fp[0] |=> !fault_q[0])
    else $error("Warning flag not cleared by status read.");

    a_event_kept: assert property ( // RULE_23
        stat_rd && fen[1] && fp[1] && mask_q.alert_output_enable
        |=> fault_q[1] && alert_q)
    else $error("Event lost in a clearing read.");

    a_transparent: assert property ( // RULE_14
        !cfg_q.latch_mode[2] |=> !lat_q[2])
    else $error("Transparent mode left the latch set.");

    a_critical_positive_flag_gate: assert property ( // RULE_22
        !mask_q.critical_pin_enable |=> pin_q[2] == !$past(hi[2]))
    else $error("Critical pin active while disabled.");

    a_reset_clear: assert property ( // RULE_11 RULE_20
        $rose(aresetn) |-> fault_q == 4'h0 && mask_q == MASK_RST &&
            cfg_q == CFG_RST && !alert_oe_q)
    else $error("State not cleared by reset.");

    a_conv_cause: assert property ( // RULE_21
        $rose(conv_q) |-> $past(conv_cycle_done))
    else $error("Conversion flag set without a finished cycle.");

    a_peak_clear: assert property ( // RULE_15
        pos_clr && !sample_valid |=> peak_pos_q == PEAK_POS_RST)
    else $error("Positive peak not reset by its clear.");
endmodule : sal_top
`default_nettype wire

// >>> test/sal_host.sv
`timescale 1ns/1ps
`default_nettype none
module sal_host (
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    int i;
    logic r;
    initial
    begin
        scl = 1'h1;
        sda_m = 1'h1;
    end
    // Clocks one bit out and samples the wired line while SCL is high.
    task bit_io(input logic b, output logic v);
        sda_m = b;
        #31 scl = 1'h1;
        #31 v = sda;
        #32 scl = 1'h0;
        #31;
    endtask : bit_io
    task ara(input logic [7:0] rival, output logic [7:0] got,
        output logic ack);
        sda_m = 1'h0;
        #62 scl = 1'h0;
        #31;
        for (i = 7; i >= 0; i--) bit_io(i == 0 || i == 3 || i == 4, r);
        bit_io(1'h1, ack);
        for (i = 7; i >= 0; i--) bit_io(rival[i], got[i]);
        bit_io(1'h1, r);
        sda_m = 1'h0;
        #31 scl = 1'h1;
        #31 sda_m = 1'h1;
    endtask : ara
endmodule : sal_host
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sal_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 1;
    logic arvalid = 0, rready = 1, awready, wready, bvalid, arready;
    logic conv_done = 0, sample_valid = 0;
    logic [15:0] sample = '0;
    sal_cfg_type cfg_o;
    logic rvalid, sda_oe, alert_oe, scl, sda_m, ack;
    logic [7:0] awaddr = '0, araddr = '0, got;
    logic [31:0] wdata = '0, rdata, d;
    logic [1:0] bresp, rresp;
    logic [2:0] watchdog_pin;
    logic [8:0] shunt_fs_mv;
    logic [5:0] bus_fs_v;
    sal_fault_type fault_present = '0;
    int n_mismatch = 0, comparisons = 0;
    wire logic sda_w = sda_m & ~sda_oe;
    sal_host host (.scl(scl), .sda_m(sda_m), .sda(sda_w));
    sal_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .fault_present(fault_present), .conv_cycle_done(conv_done),
        .sample_valid(sample_valid), .sample(sample), .scl_i(scl),
        .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .alert_o(),
        .alert_oe(alert_oe), .watchdog_pin(watchdog_pin), .cfg_o(cfg_o),
        .shunt_fs_mv(shunt_fs_mv), .bus_fs_v(bus_fs_v));
    initial
    begin
        forever #5 aclk = ~aclk;
    end
    task end_sim;
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 0;
            if (wready)
                wvalid <= 0;
        end
        while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge aclk); while (!bvalid);
    endtask : wr
    task rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
    endtask : rd
    task t_reset;
        chk(alert_oe, 0);
        chk(watchdog_pin, 7);
        rd(ADDR_STATUS);
        chk(d, 0);
        chk(rresp, RESP_OKAY);
    endtask : t_reset
    task t_alert;
        wr(ADDR_MASK, 32'h00000005);
        fault_present <= 4'h1;
        repeat (3) @(posedge aclk);
        chk(alert_oe, 1);
        fault_present <= 4'h0;
        repeat (4) @(posedge aclk);
        chk(alert_oe, 1);
        rd(ADDR_STATUS);
        chk(d, 32'h00000021);
        @(posedge aclk);
        chk(alert_oe, 0);
        fault_present <= 4'h1;
        repeat (3) @(posedge aclk);
        rd(ADDR_STATUS);
        @(posedge aclk);
        chk(alert_oe, 1);
        wr(ADDR_MASK, 32'h00000004);
        repeat (2) @(posedge aclk);
        chk(alert_oe, 0);
        fault_present <= 4'h0;
    endtask : t_alert
    task t_ara;
        wr(ADDR_MASK, 32'h00000005);
        fault_present <= 4'h1;
        @(posedge aclk);
        fault_present <= 4'h0;
        repeat (3) @(posedge aclk);
        host.ara(8'h7F, got, ack);
        chk(got, 32'h0000007F);
        repeat (3) @(posedge aclk);
        chk(alert_oe, 1);
        host.ara(8'hFF, got, ack);
        chk(ack, 0);
        chk(got, 32'h00000080);
        repeat (3) @(posedge aclk);
        chk(alert_oe, 0);
    endtask : t_ara
    task t_conv;
        wr(ADDR_MASK, 32'h00000021);
        wr(ADDR_CONFIG, 32'h00020000);
        conv_done <= 1;
        sample_valid <= 1;
        sample <= 16'h1234;
        @(posedge aclk);
        conv_done <= 0;
        sample_valid <= 0;
        @(posedge aclk);
        chk(alert_oe, 1);
        rd(ADDR_STATUS);
        chk(d, 32'h00000031);
        rd(ADDR_STATUS);
        chk(d, 32'h00000000);
        rd(ADDR_PEAK_POS);
        chk(d, 32'h00001234);
        wr(ADDR_PEAK_POS, 32'h00000001);
        chk(bresp, RESP_OKAY);
        rd(ADDR_PEAK_POS);
        chk(d, 32'h00008000);
    endtask : t_conv
    task t_range;
        wr(ADDR_CONFIG, 32'h0000B5C4);
        repeat (2) @(posedge aclk);
        chk(shunt_fs_mv, 32'h00000140);
        chk(bus_fs_v, 32'h00000020);
        chk(cfg_o, 32'h0000B5C4);
    endtask : t_range
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset();
        t_alert();
        t_ara();
        t_conv();
        t_range();
        end_sim();
    end
    initial
    begin
        #200000;
        n_mismatch++;
        end_sim();
    end
endmodule : testbench
`default_nettype wire
